/* File: design/pct_pkg.sv */
// Package with register map, field layout and timing constants of the counter.
package pct_pkg;

   localparam logic [7:0] PCT_ADDR_MODE = 8'hD9;
   localparam logic [7:0] PCT_ADDR_LOW  = 8'hF9;
   localparam logic [7:0] PCT_ADDR_HIGH = 8'hFA;

   localparam logic [7:0] PCT_MODE_RESET = 8'h40;
   localparam logic [7:0] PCT_MODE_WMASK = 8'hEF;
   localparam logic [7:0] PCT_BYTE_RESET = 8'h00;

   localparam int PCT_BIT_IDLE = 7;
   localparam int PCT_BIT_WDE  = 6;
   localparam int PCT_BIT_LOCK = 5;
   localparam int PCT_BIT_SELH = 3;
   localparam int PCT_BIT_SELL = 1;
   localparam int PCT_BIT_IRQE = 0;

   localparam logic [2:0] PCT_SEL_DIV12 = 3'h0;
   localparam logic [2:0] PCT_SEL_DIV4  = 3'h1;
   localparam logic [2:0] PCT_SEL_T0OV  = 3'h2;
   localparam logic [2:0] PCT_SEL_EXTIN = 3'h3;
   localparam logic [2:0] PCT_SEL_SYS   = 3'h4;
   localparam logic [2:0] PCT_SEL_XOSC  = 3'h5;

   localparam logic [3:0] PCT_DIV12_LAST = 4'hB;
   localparam logic [3:0] PCT_DIV4_LAST  = 4'h3;
   localparam logic [2:0] PCT_XDIV_LAST  = 3'h7;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pct_bus_t;

endpackage

/* File: design/pct_counter.sv */
// Programmable 16-bit counter/timer with timebase select and watchdog lock.
//
// How it works
// - Sixteen-bit counter exposed as readable, writable low and high bytes.
// - High byte reads return a snapshot taken when the low byte is read.
// - Timebase codes 0, 1, 4 pick system clock over 12, over 4, undivided.
// - Code 2 counts Timer 0 overflows; code 3 counts falling edges of input.
// - Code 5 counts synchronised external oscillator over 8; 6, 7 reserved.
// - With idle suspend set, counting stops while the processor idles.
// - Watchdog enable bit hands compare module 4 the watchdog role.
// - Once locked, the watchdog enable cannot be cleared until reset.
// - Overflow interrupt enable gates the request from the overflow flag.
// - While watchdog enabled, writes to the low byte are ignored.
// - While watchdog enabled, writes to the high byte are ignored.
`timescale 1ns/1ns
module pct_counter
   import pct_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire pct_bus_t   bus,
   input  wire logic       overflow_flag_clear,
   input  wire logic       cpu_idle,
   input  wire logic       timer0_overflow,
   input  wire logic       external_count_input,
   input  wire logic       ext_osc_clk,
   output logic [7:0]      rdata,
   output logic            counter_overflow_flag,
   output logic            overflow_irq,
   output logic            watchdog_active
);

   logic [7:0]  mode_q,  mode_d;
   logic [15:0] cnt_q,   cnt_d;
   logic [7:0]  snap_q,  snap_d;
   logic        ovf_q,   ovf_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        irq_q,   irq_d;
   logic        wd_q,    wd_d;
   logic [3:0]  pre_q,   pre_d;
   logic [2:0]  xdiv_q,  xdiv_d;
   logic [2:0]  ein_q,   ein_d;
   logic [2:0]  xin_q,   xin_d;
   logic        t0_q,    t0_d;

   logic [2:0]  sel;
   logic        tick;
   logic        wd_on;
   logic        wrap;

   function automatic logic hit(input pct_bus_t b, input logic [7:0] a);
      return b.addr == a;
   endfunction

   assign sel   = mode_q[PCT_BIT_SELH:PCT_BIT_SELL];
   assign wd_on = mode_q[PCT_BIT_WDE];
   // All ones is the last count before the wrap, whatever the width.
   assign wrap  = tick & (&cnt_q);

   // The first stage of the count-input and oscillator synchronisers feeds only the second stage; Timer 0 has one stage.
   always_comb begin
      ein_d = {ein_q[1:0], external_count_input};
      xin_d = {xin_q[1:0], ext_osc_clk};
      t0_d  = timer0_overflow;
   end

   // Timebase generation.
   always_comb begin
      pre_d  = pre_q + 4'h1;
      xdiv_d = xdiv_q;
      tick   = 1'b0;
      case (sel)
         PCT_SEL_DIV12: begin
            tick = (pre_q == PCT_DIV12_LAST);
         end
         PCT_SEL_DIV4: begin
            tick = (pre_q >= PCT_DIV4_LAST);
         end
         PCT_SEL_T0OV: begin
            tick = t0_q;
         end
         PCT_SEL_EXTIN: begin
            // Three-stage edge detect limits the useful rate to half the clock.
            tick = ein_q[2] & ~ein_q[1];
         end
         PCT_SEL_SYS: begin
            tick = 1'b1;
         end
         PCT_SEL_XOSC: begin
            // A rising edge of the synchronised oscillator steps the divider.
            if (xin_q[1] & ~xin_q[2]) begin
               xdiv_d = xdiv_q + 3'h1;
               tick   = (xdiv_q == PCT_XDIV_LAST);
            end
         end
         default: begin
            // Reserved codes hold the count rather than guess a source.
            tick = 1'b0;
         end
      endcase
      if (tick || (sel == PCT_SEL_DIV4 && pre_q >= PCT_DIV4_LAST)) begin
         pre_d = 4'h0;
      end
      if (mode_q[PCT_BIT_IDLE] && cpu_idle) begin
         tick = 1'b0;
      end
   end

   // Registers, counter and overflow flag.
   always_comb begin
      mode_d  = mode_q;
      cnt_d   = cnt_q;
      snap_d  = snap_q;
      ovf_d   = ovf_q;
      rdata_d = rdata_q;
      if (tick) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (overflow_flag_clear) begin
         ovf_d = 1'b0;
      end
      // A wrap in the same cycle as a clear keeps the flag set.
      if (wrap) begin
         ovf_d = 1'b1;
      end
      if (bus.wr) begin
         if (hit(bus, PCT_ADDR_MODE)) begin
            if (wd_on) begin
               // Only the enable may change, and not at all once locked.
               if (!mode_q[PCT_BIT_LOCK]) begin
                  mode_d[PCT_BIT_WDE] = bus.wdata[PCT_BIT_WDE];
               end
            end else begin
               mode_d = bus.wdata & PCT_MODE_WMASK;
               // The lock is sticky even while the watchdog is off, so a
               // later write cannot drop it and then clear the enable.
               mode_d[PCT_BIT_LOCK] = bus.wdata[PCT_BIT_LOCK]
                                    | mode_q[PCT_BIT_LOCK];
            end
         end else if (hit(bus, PCT_ADDR_LOW)) begin
            if (!wd_on) begin
               cnt_d[7:0] = bus.wdata;
            end
         end else if (hit(bus, PCT_ADDR_HIGH)) begin
            if (!wd_on) begin
               cnt_d[15:8] = bus.wdata;
            end
         end
      end
      if (bus.rd) begin
         if (hit(bus, PCT_ADDR_MODE)) begin
            rdata_d = mode_q;
         end else if (hit(bus, PCT_ADDR_LOW)) begin
            rdata_d = cnt_q[7:0];
            // Freezing the high byte here makes a low-then-high read
            // coherent even while the counter runs.
            snap_d  = cnt_q[15:8];
         end else if (hit(bus, PCT_ADDR_HIGH)) begin
            rdata_d = snap_q;
         end else begin
            // An unmapped read answers zero rather than stale data.
            rdata_d = PCT_BYTE_RESET;
         end
      end
      irq_d = ovf_d & mode_d[PCT_BIT_IRQE];
      wd_d  = mode_d[PCT_BIT_WDE];
   end

   // Synchroniser history resets to the resting level of each pin: the
   // count input rests high, so no false falling edge follows reset.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ein_q <= 3'h7;
         xin_q <= 3'h0;
         t0_q  <= 1'b0;
      end else begin
         ein_q <= ein_d;
         xin_q <= xin_d;
         t0_q  <= t0_d;
      end
   end

   // The prescaler runs in every mode, so the first period after a change
   // of timebase may be short or long; a clean restart was not worth it.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pre_q  <= 4'h0;
         xdiv_q <= 3'h0;
      end else begin
         pre_q  <= pre_d;
         xdiv_q <= xdiv_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mode_q  <= PCT_MODE_RESET;
         cnt_q   <= {PCT_BYTE_RESET, PCT_BYTE_RESET};
         snap_q  <= PCT_BYTE_RESET;
         ovf_q   <= 1'b0;
         rdata_q <= PCT_BYTE_RESET;
         irq_q   <= 1'b0;
         wd_q    <= PCT_MODE_RESET[PCT_BIT_WDE];
      end else begin
         mode_q  <= mode_d;
         cnt_q   <= cnt_d;
         snap_q  <= snap_d;
         ovf_q   <= ovf_d;
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
         wd_q    <= wd_d;
      end
   end

   assign rdata                 = rdata_q;
   assign counter_overflow_flag = ovf_q;
   assign overflow_irq          = irq_q;
   assign watchdog_active       = wd_q;

endmodule

/* File: dv/pct_checker.sv */
// Port assertions for the counter, bound into it.
`timescale 1ns/1ns
module pct_checker
   import pct_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire pct_bus_t   bus,
   input wire logic       overflow_flag_clear,
   input wire logic [7:0] rdata,
   input wire logic       counter_overflow_flag,
   input wire logic       overflow_irq,
   input wire logic       watchdog_active
);
   wire  wm = bus.wr && bus.addr == PCT_ADDR_MODE;
   wire  rm = bus.rd && bus.addr == PCT_ADDR_MODE;
   logic clr_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge clk)
      clr_q <= wm && !bus.wdata[6];
   sequence flag_low2;
      !counter_overflow_flag ##1 !counter_overflow_flag;
   endsequence
   wde_reset_a: assert property ($rose(reset_n) |-> watchdog_active)
      else $error("wde reset");
   wde_set_a: assert property (wm && bus.wdata[6] |=> watchdog_active)
      else $error("wde set");
   wde_clear_a: assert property ($fell(watchdog_active) |-> clr_q)
      else $error("wde clear");
   irq_mask_a: assert property (flag_low2 |-> !overflow_irq)
      else $error("irq mask");
   flag_hold_a: assert property (counter_overflow_flag
      && !overflow_flag_clear |=> counter_overflow_flag)
      else $error("flag hold");
   rdata_hold_a: assert property (!bus.rd |=> $stable(rdata))
      else $error("rdata hold");
   mode_rd_a: assert property (rm |=>
      rdata[6] == $past(watchdog_active))
      else $error("mode read");
   bit4_zero_a: assert property (rm |=> !rdata[4])
      else $error("bit4 read");
endmodule
bind pct_counter pct_checker pct_checker_inst (.clk, .reset_n, .bus,
   .overflow_flag_clear, .rdata, .counter_overflow_flag, .overflow_irq,
   .watchdog_active);

/* File: dv/tb.sv */
// Self-checking bench for the counter.
`timescale 1ns/1ns
module tb;
   import pct_pkg::*;
   localparam logic [7:0] M = PCT_ADDR_MODE, L = PCT_ADDR_LOW;
   localparam logic [7:0] H = PCT_ADDR_HIGH;
   logic       clk = 0, reset_n = 0, clr = 0, idle = 0, t0 = 0;
   logic       flag, irq, wd;
   logic [7:0] rdata, v, a;
   pct_bus_t   bus = '0;
   int         cyc = 0, num_errors = 0, compares = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= #1 cyc + 1;
      t0  <= #1 cyc % 8 == 0;
   end
   pct_counter pct_counter_inst (.clk, .reset_n, .bus,
      .overflow_flag_clear(clr), .cpu_idle(idle), .timer0_overflow(t0),
      .external_count_input(cyc[3]), .ext_osc_clk(cyc[1]), .rdata,
      .counter_overflow_flag(flag), .overflow_irq(irq), .watchdog_active(wd));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic final_report;
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cy(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(logic w, logic [7:0] ad, logic [7:0] d);
      @(posedge clk) #1 bus = '{w, !w, ad, d};
      cy(1);
      bus = '0;
      v = rdata;
   endtask
   task automatic t_prot;
      acc(1, L, 8'hE5);
      acc(1, H, 8'h55);
      acc(0, L, 0);
      chk("low", 8'h00, v & 8'hE0);
      acc(0, H, 0);
      chk("high", 8'h00, v);
      acc(1, M, 8'hAF);
      acc(0, M, 0);
      chk("mode", 8'h00, v);
      chk("wd", 8'h00, {7'h0, wd});
      acc(1, M, 8'h20);
      acc(1, M, 8'h60);
      acc(1, M, 8'h00);
      acc(0, M, 0);
      chk("mode", 8'h60, v);
   endtask
   task automatic t_count;
      logic [7:0] m[9] = '{8'h00, 2, 4, 6, 8, 8'h0A, 8'h0C, 8'h88, 8};
      logic [7:0] e[9] = '{8, 24, 12, 6, 96, 3, 0, 0, 96};
      for (int k = 0; k < 9; k++) begin
         idle = k > 6;
         acc(1, M, m[k]);
         acc(0, L, 0);
         a = v;
         cy(94);
         acc(0, L, 0);
         chk("delta", e[k], v - a);
      end
      idle = 0;
   endtask
   task automatic t_snap;
      acc(1, M, 8'h1C);
      acc(0, M, 0);
      chk("mode", 8'h0C, v);
      acc(1, L, 8'hF8);
      acc(1, H, 8'h34);
      acc(0, L, 0);
      chk("low", 8'hF8, v);
      acc(0, H, 0);
      chk("high", 8'h34, v);
      acc(1, M, 8'h08);
      cy(20);
      acc(0, H, 0);
      chk("stale", 8'h34, v);
      acc(0, L, 0);
      acc(0, H, 0);
      chk("fresh", 8'h35, v);
   endtask
   task automatic t_ovf;
      acc(1, M, 8'h0C);
      acc(1, L, 8'hF0);
      acc(1, H, 8'hFF);
      acc(1, M, 8'h08);
      for (int i = 0; i < 40 && flag !== 1'b1; i++)
         cy(1);
      chk("flag", 8'h01, {7'h0, flag});
      if (flag !== 1'b1)
         final_report;
      cy(2);
      chk("irq", 8'h00, {7'h0, irq});
      acc(1, M, 8'h09);
      cy(2);
      chk("irq", 8'h01, {7'h0, irq});
      clr = 1;
      cy(1);
      clr = 0;
      cy(2);
      chk("flag", 8'h00, {7'h0, flag});
      chk("irq", 8'h00, {7'h0, irq});
   endtask
   initial begin
      cy(5);
      reset_n = 1;
      acc(0, M, 0);
      chk("mode", 8'h40, v);
      chk("wd", 8'h01, {7'h0, wd});
      t_prot;
      reset_n = 0;
      cy(5);
      reset_n = 1;
      acc(1, M, 8'h00);
      acc(0, M, 0);
      chk("mode", 8'h00, v);
      t_count;
      t_snap;
      t_ovf;
      final_report;
   end
endmodule
